// ===== design/acd_defs.vh
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// ----------------------------------------------------------------
// trigger qualification, in converter clock periods
// ----------------------------------------------------------------
`define ACD_TRIG_LOW_MIN    4'ha
`define ACD_TRIG_HIGH_MIN   4'ha

// ----------------------------------------------------------------
// conversion latency per bus, in converter clock periods
// ----------------------------------------------------------------
`define ACD_LAT_EARLIER     4'h8
`define ACD_LAT_LATER       4'h7

// ----------------------------------------------------------------
// input span, millivolts
// ----------------------------------------------------------------
`define ACD_HALF_NARROW_MV  9'h12c
`define ACD_HALF_WIDE_MV    9'h190
`define ACD_SPAN_NARROW_MV  18'h00258
`define ACD_SPAN_WIDE_MV    18'h00320

// ----------------------------------------------------------------
// output code reset value and clipping limits
// ----------------------------------------------------------------
`define ACD_CODE_MID        8'h80
`define ACD_CODE_MAX        8'hff
`define ACD_CODE_MIN        8'h00

// ----------------------------------------------------------------
// default wait and self-trim lengths, converter clock periods
// ----------------------------------------------------------------
`define ACD_WAIT_SHORT_DEF  17'h00400
`define ACD_WAIT_LONG_DEF   17'h10000
`define ACD_TRIM_LEN_DEF    17'h00578

`endif

// ===== design/acd_sync.v
`default_nettype none

// ----------------------------------------------------------------
// two-stage synchroniser, one lane per bit
// ----------------------------------------------------------------
module acd_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;

endmodule

`default_nettype wire

// ===== design/acd_ctrl_demux.v
// Overview of operation
// - A sample is taken at each falling edge of the converter clock input, except while asleep.
// - Successive samples go alternately to two buses, each at half rate, interleaved.
// - Each output word is 8 bits in offset binary.
// - Launch polarity high moves data with the strobe rising edge, low with its falling edge.
// - Sleep request high holds the block powered down, low lets it convert.
// - Trigger low for 10 periods then high for 10 periods starts self-trim.
// - The wait select picks how many periods pass after power-up before automatic self-trim.
// - Span select low gives a 600 mV full scale, high gives 800 mV.
// - Swing select high gives normal output amplitude, low gives reduced amplitude.
// - Bias select high means dc coupled inputs, low means internal bias for ac coupling.
// - Samples appear 8 periods (earlier bus) or 7 periods (later bus) after being taken.
// - The self-trim active output is high exactly while self-trim runs.
// - The earlier bus carries the first sample of a pair, the later bus the second.
// - The overrange flag rises when the input lies outside the selected span.
`include "acd_defs.vh"
`default_nettype none

module acd_ctrl_demux #(
	parameter [16:0] WAIT_SHORT_CYCLES = `ACD_WAIT_SHORT_DEF,
	parameter [16:0] WAIT_LONG_CYCLES  = `ACD_WAIT_LONG_DEF,
	parameter [16:0] TRIM_CYCLES       = `ACD_TRIM_LEN_DEF
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        conv_clk_pin,
	input  wire [10:0] vin_mv,
	input  wire        selftrim_trigger,
	input  wire        selftrim_wait_select,
	input  wire        sleep_request,
	input  wire        input_span_select,
	input  wire        swing_select,
	input  wire        input_bias_select,
	input  wire        launch_polarity_select,
	output reg  [7:0]  earlier_bus,
	output reg  [7:0]  later_bus,
	output reg         output_strobe,
	output reg         overrange_flag,
	output reg         selftrim_active,
	output reg         power_down,
	output reg         span_wide,
	output reg         swing_normal,
	output reg         internal_bias_en
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [1:0] ST_WAIT  = 2'h0;
	localparam [1:0] ST_RUN   = 2'h1;
	localparam [1:0] ST_TRIM  = 2'h2;
	localparam [1:0] ST_SLEEP = 2'h3;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire [7:0]  pins_s;
	wire [10:0] vin_s;

	acd_sync #(
		.W (8)
	) u_sync_pins (
		.clk (sys_clk),
		.rst (rst),
		.d   ({conv_clk_pin, selftrim_trigger, selftrim_wait_select, sleep_request,
		       input_span_select, swing_select, input_bias_select, launch_polarity_select}),
		.q   (pins_s)
	);

	// lanes may skew by a cycle; vin is steady long before a conv fall is seen
	acd_sync #(
		.W (11)
	) u_sync_vin (
		.clk (sys_clk),
		.rst (rst),
		.d   (vin_mv),
		.q   (vin_s)
	);

	wire conv_s   = pins_s[7];
	wire trig_s   = pins_s[6];
	wire waitsel_s = pins_s[5];
	wire sleep_s  = pins_s[4];
	wire span_s   = pins_s[3];
	wire swing_s  = pins_s[2];
	wire bias_s   = pins_s[1];
	wire pol_s    = pins_s[0];

	// ----------------------------------------------------------------
	// converter clock edge finder
	// ----------------------------------------------------------------
	// resets to the cleared synchroniser level, so no false fall after reset
	reg  conv_prev_reg;
	wire conv_fall = conv_prev_reg & ~conv_s;

	always @(posedge sys_clk) begin
		if (rst)
			conv_prev_reg <= 1'b0;
		else
			conv_prev_reg <= conv_s;
	end

	// ----------------------------------------------------------------
	// quantiser
	// ----------------------------------------------------------------
	wire signed [11:0] vin_ext   = {vin_s[10], vin_s};
	wire        [8:0]  half_mv   = span_s ? `ACD_HALF_WIDE_MV : `ACD_HALF_NARROW_MV;
	wire signed [11:0] shifted   = vin_ext + $signed({3'h0, half_mv});
	wire signed [11:0] span_full = $signed({2'h0, half_mv, 1'b0});
	wire               ovr_lo    = shifted < 12'sh000;
	wire               ovr_hi    = shifted > span_full;
	wire        [17:0] scaled    = {shifted[9:0], 8'h00};
	wire        [17:0] quot      = span_s ? (scaled / `ACD_SPAN_WIDE_MV)
	                                      : (scaled / `ACD_SPAN_NARROW_MV);
	reg         [7:0]  code;

	always @* begin
		if (ovr_lo)
			code = `ACD_CODE_MIN;
		else if (ovr_hi || (quot[17:8] != 10'h000))
			code = `ACD_CODE_MAX;
		else
			code = quot[7:0];
	end

	// ----------------------------------------------------------------
	// self-trim trigger qualifier
	// ----------------------------------------------------------------
	// a high run cut short disarms; a fresh low run is needed
	reg [3:0] low_cnt_reg;
	reg [3:0] high_cnt_reg;
	reg       armed_reg;
	reg       trim_req_reg;

	always @(posedge sys_clk) begin
		if (rst) begin
			low_cnt_reg  <= 4'h0;
			high_cnt_reg <= 4'h0;
			armed_reg    <= 1'b0;
			trim_req_reg <= 1'b0;
		end else begin
			trim_req_reg <= 1'b0;
			if (conv_fall) begin
				if (!trig_s) begin
					high_cnt_reg <= 4'h0;
					if (low_cnt_reg != `ACD_TRIG_LOW_MIN)
						low_cnt_reg <= low_cnt_reg + 4'h1;
					armed_reg <= (low_cnt_reg >= (`ACD_TRIG_LOW_MIN - 4'h1));
				end else begin
					low_cnt_reg <= 4'h0;
					if (armed_reg) begin
						if (high_cnt_reg == (`ACD_TRIG_HIGH_MIN - 4'h1)) begin
							trim_req_reg <= 1'b1;
							armed_reg    <= 1'b0;
							high_cnt_reg <= 4'h0;
						end else begin
							high_cnt_reg <= high_cnt_reg + 4'h1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// power-up wait, self-trim and sleep sequencer
	// ----------------------------------------------------------------
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [16:0] cnt_reg;
	reg  [16:0] cnt_next;
	wire [16:0] wait_target = waitsel_s ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES;

	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
		ST_WAIT: begin
			if (conv_fall) begin
				if (cnt_reg >= wait_target - 17'h00001) begin
					state_next = ST_TRIM;
					cnt_next   = 17'h00000;
				end else begin
					cnt_next = cnt_reg + 17'h00001;
				end
			end
		end
		ST_RUN: begin
			if (trim_req_reg) begin
				state_next = ST_TRIM;
				cnt_next   = 17'h00000;
			end
		end
		ST_TRIM: begin
			if (conv_fall) begin
				if (cnt_reg >= TRIM_CYCLES - 17'h00001) begin
					state_next = ST_RUN;
					cnt_next   = 17'h00000;
				end else begin
					cnt_next = cnt_reg + 17'h00001;
				end
			end
		end
		ST_SLEEP: begin
			if (!sleep_s) begin
				state_next = ST_WAIT;
				cnt_next   = 17'h00000;
			end
		end
		default: begin
			state_next = ST_WAIT;
			cnt_next   = 17'h00000;
		end
		endcase
		// sleep overrides every state; waking repeats the power-up wait
		if (sleep_s) begin
			state_next = ST_SLEEP;
			cnt_next   = 17'h00000;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_WAIT;
			cnt_reg   <= 17'h00000;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// latency pipeline and 1:2 demultiplexer
	// ----------------------------------------------------------------
	reg  [8:0] pipe_reg [0:7];
	reg        phase_reg;
	wire       sampling = conv_fall && (state_reg != ST_SLEEP);
	wire       launch   = sampling && !phase_reg;
	integer    i;

	always @(posedge sys_clk) begin
		if (rst) begin
			for (i = 0; i < 8; i = i + 1)
				pipe_reg[i] <= {1'b0, `ACD_CODE_MID};
			phase_reg <= 1'b0;
		end else if (sampling) begin
			pipe_reg[0] <= {ovr_lo | ovr_hi, code};
			for (i = 1; i < 8; i = i + 1)
				pipe_reg[i] <= pipe_reg[i-1];
			phase_reg <= ~phase_reg;
		end
	end

	// ----------------------------------------------------------------
	// output launch
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			earlier_bus    <= `ACD_CODE_MID;
			later_bus      <= `ACD_CODE_MID;
			overrange_flag <= 1'b0;
			output_strobe  <= 1'b0;
		end else if (state_reg == ST_SLEEP) begin
			output_strobe  <= 1'b0;
			overrange_flag <= 1'b0;
		end else if (sampling) begin
			output_strobe <= launch ? pol_s : ~pol_s;
			// buses freeze from the edge that enters self-trim, as selftrim_active does
			if (launch && (state_next != ST_TRIM)) begin
				earlier_bus    <= pipe_reg[`ACD_LAT_EARLIER-1][7:0];
				later_bus      <= pipe_reg[`ACD_LAT_LATER-1][7:0];
				overrange_flag <= pipe_reg[`ACD_LAT_EARLIER-1][8] |
				                  pipe_reg[`ACD_LAT_LATER-1][8];
			end
		end
	end

	// ----------------------------------------------------------------
	// static mode outputs and self-trim indication
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (rst) begin
			selftrim_active  <= 1'b0;
			power_down       <= 1'b0;
			span_wide        <= 1'b0;
			swing_normal     <= 1'b0;
			internal_bias_en <= 1'b0;
		end else begin
			selftrim_active  <= (state_next == ST_TRIM);
			power_down       <= (state_next == ST_SLEEP);
			span_wide        <= span_s;
			swing_normal     <= swing_s;
			internal_bias_en <= ~bias_s;
		end
	end

endmodule

`default_nettype wire

// ===== design/acd_defs_note_unused.v
`default_nettype none
`default_nettype wire

// ===== dv/acd_properties.sv
`default_nettype none
module acd_properties (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       sleep_request,
	input wire logic       input_span_select,
	input wire logic       swing_select,
	input wire logic       input_bias_select,
	input wire logic       launch_polarity_select,
	input wire logic [7:0] earlier_bus,
	input wire logic [7:0] later_bus,
	input wire logic       output_strobe,
	input wire logic       overrange_flag,
	input wire logic       selftrim_active,
	input wire logic       power_down,
	input wire logic       span_wide,
	input wire logic       swing_normal,
	input wire logic       internal_bias_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sleep_enter_a: assert property (sleep_request [*5] |-> power_down)
		else $error("power_down late");
	sleep_quiet_a: assert property (power_down && $past(power_down) |-> !output_strobe && !selftrim_active)
		else $error("activity while asleep");
	span_copy_a: assert property ($stable(input_span_select) [*5] |-> span_wide == input_span_select)
		else $error("span_wide wrong");
	swing_copy_a: assert property ($stable(swing_select) [*5] |-> swing_normal == swing_select)
		else $error("swing_normal wrong");
	bias_invert_a: assert property ($stable(input_bias_select) [*5] |-> internal_bias_en == !input_bias_select)
		else $error("internal_bias_en wrong");
	bus_pair_a: assert property ($changed({earlier_bus, later_bus}) |-> $changed(output_strobe))
		else $error("bus moved without strobe");
	launch_edge_a: assert property ($changed({earlier_bus, later_bus}) |-> output_strobe == launch_polarity_select)
		else $error("data moved on wrong strobe edge");
	ovr_code_a: assert property (overrange_flag |->
		earlier_bus inside {8'h00, 8'hff} || later_bus inside {8'h00, 8'hff})
		else $error("overrange without clipped code");
	trim_hold_a: assert property (selftrim_active |-> $stable(earlier_bus) && $stable(later_bus))
		else $error("bus moved during self-trim");
endmodule
bind acd_ctrl_demux acd_properties u_acd_properties (.*);
`default_nettype wire

// ===== dv/acd_rx_model.sv
`default_nettype none
module acd_rx_model (
	input wire logic       sys_clk,
	input wire logic [7:0] earlier_bus,
	input wire logic [7:0] later_bus,
	input wire logic       overrange_flag,
	input wire logic       output_strobe,
	input wire logic       launch_polarity_select,
	output var logic [8:0] cap_early,
	output var logic [7:0] cap_late,
	output var logic       cap_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic strobe_prev;
	// capture on the non-launch strobe edge, mid-eye
	always @(posedge sys_clk) begin
		strobe_prev <= output_strobe;
		cap_valid <= output_strobe != strobe_prev && output_strobe != launch_polarity_select;
		cap_early <= {overrange_flag, earlier_bus};
		cap_late <= later_bus;
	end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0, rst = 1'b1, conv_clk_pin = 1'b1, selftrim_trigger = 1'b1;
	logic        selftrim_wait_select = 1'b0, sleep_request = 1'b0, input_span_select = 1'b0;
	logic        swing_select = 1'b1, input_bias_select = 1'b0, launch_polarity_select = 1'b0;
	logic [10:0] vin_mv = 11'h000;
	logic [7:0]  earlier_bus, later_bus, cap_late;
	logic        output_strobe, overrange_flag, selftrim_active, power_down, span_wide, swing_normal;
	logic        internal_bias_en, cap_valid, chk_en = 1'b0;
	logic [8:0]  cap_early;
	logic [8:0]  qh [0:1023];
	logic [10:0] corner [0:7] = '{-11'h12d, -11'h12c, 11'h000, 11'h12b, 11'h12c, 11'h12d, 11'h190, -11'h191};
	logic [31:0] rs = 32'h1a;
	int          err_count = 0, comparisons = 0, cnt = 0, n0, ci = 8;

	acd_ctrl_demux #(.WAIT_SHORT_CYCLES(17'h4), .WAIT_LONG_CYCLES(17'h8), .TRIM_CYCLES(17'h6)) u_acd_ctrl_demux (.*);
	acd_rx_model u_acd_rx_model (.*);

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	// {overrange, offset binary code}
	function automatic logic [8:0] quant(input logic [10:0] v, input logic wide);
		int h, s;
		h = wide ? 32'h190 : 32'h12c;
		s = $signed(v) + h;
		if (s < 0) return 9'h100;
		if (s > 2 * h) return 9'h1ff;
		s = s * 32'h100 / (2 * h);
		return (s > 32'hff) ? 9'h0ff : 9'(s);
	endfunction

	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic period(input int n);
		repeat (n) begin
			@(posedge conv_clk_pin);
			@(negedge sys_clk);
			check("swing_bias", {7'h00, swing_normal, internal_bias_en}, {7'h00, swing_select, ~input_bias_select});
			vin_mv = (ci < 8) ? corner[ci] : 11'(rnd() % 32'h385 - 32'h1c2);
			ci++;
			{swing_select, input_bias_select} = 2'(rnd());
		end
	endtask

	task automatic wait_trim(input logic lvl);
		int i;
		for (i = 0; i < 5000 && selftrim_active !== lvl; i++) @(negedge sys_clk);
		if (selftrim_active !== lvl) begin
			err_count++;
			report_and_stop();
		end
	endtask

	initial forever #2 sys_clk = ~sys_clk;

	// converter clock, unrelated phase; logs each sample taken
	initial begin
		#5;
		forever begin
			conv_clk_pin = 1'b0;
			if (!rst) begin
				qh[cnt] = quant(vin_mv, input_span_select);
				cnt++;
			end
			#32 conv_clk_pin = 1'b1;
			#32;
		end
	end

	always @(negedge sys_clk) begin
		if (chk_en && cap_valid === 1'b1 && cnt >= 10) begin
			check("earlier_bus", cap_early, {qh[cnt-10][8] | qh[cnt-9][8], qh[cnt-10][7:0]});
			check("later_bus", {1'b0, cap_late}, {1'b0, qh[cnt-9][7:0]});
		end
	end

	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		check("reset_early", {output_strobe, earlier_bus}, 9'h080);
		check("reset_late", {selftrim_active, later_bus}, 9'h080);
		wait_trim(1'b1);
		check("short_wait", cnt inside {4, 5}, 9'h001);
		n0 = cnt;
		wait_trim(1'b0);
		check("trim_length", (cnt - n0) inside {6, 7}, 9'h001);
		$display("test power-up self-trim done");
		for (int w = 0; w < 2; w++) begin
			// change polarity only just after a launch, so no launch edge goes missing
			for (int k = 0; k < 3 && output_strobe !== launch_polarity_select; k++) period(1);
			check("strobe_phase", {8'h00, output_strobe}, {8'h00, launch_polarity_select});
			input_span_select = w[0];
			launch_polarity_select = w[0];
			period(12);
			check("span_wide", {8'h00, span_wide}, {8'h00, input_span_select});
			ci = 0;
			chk_en = 1'b1;
			period(40);
			chk_en = 1'b0;
			$display("test data span %0d done", w);
		end
		selftrim_trigger = 1'b0;
		period(10);
		selftrim_trigger = 1'b1;
		period(9);
		selftrim_trigger = 1'b0;
		period(3);
		check("short_high", {8'h00, selftrim_active}, 9'h000);
		period(10);
		selftrim_trigger = 1'b1;
		period(9);
		check("nine_high", {8'h00, selftrim_active}, 9'h000);
		period(1);
		check("ten_high", {8'h00, selftrim_active}, 9'h001);
		wait_trim(1'b0);
		$display("test trigger done");
		selftrim_wait_select = 1'b1;
		sleep_request = 1'b1;
		period(3);
		check("sleep", {7'h00, output_strobe, power_down}, 9'h001);
		sleep_request = 1'b0;
		n0 = cnt;
		wait_trim(1'b1);
		check("long_wait", (cnt - n0) inside {8, 9}, 9'h001);
		wait_trim(1'b0);
		$display("test sleep and long wait done");
		report_and_stop();
	end
endmodule
`default_nettype wire
